// ==== verilog/edc_pkg.sv ====
// Shared constants for the configuration memory error checker and its reader.
// Assumes both ends run on one 20 MHz clock with a synchronous reset.
package edc_pkg;
  // Message and register widths
  localparam int MSG_W = 46;
  localparam int SYN_W = 32;
  localparam int FI_W = 21;
  // Error message layout: type, frame, bit, syndrome
  localparam int TYPE_HI = 45;
  localparam int TYPE_LO = 44;
  localparam int LOCF_HI = 43;
  localparam int LOCF_LO = 40;
  localparam int LOCF_W = LOCF_HI - LOCF_LO + 1;
  localparam int LOCB_HI = 39;
  localparam int LOCB_LO = 32;
  localparam int LOCB_W = LOCB_HI - LOCB_LO + 1;
  // Fault injection layout: type, frame, bit
  localparam int FI_TYPE_HI = 20;
  localparam int FI_TYPE_LO = 19;
  localparam int FI_FR_HI = 18;
  localparam int FI_FR_LO = 10;
  localparam int FI_BIT_HI = 9;
  localparam int FI_BIT_LO = 0;
  // Error type codes
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_SINGLE = 2'h1;
  localparam logic [1:0] ERR_DOUBLE = 2'h2;
  localparam logic [1:0] ERR_MULTI = 2'h3;
  // Frame check polynomial, zero initial value
  localparam logic [SYN_W-1:0] CRC_POLY = 32'h04c11db7;
  // Checker step: clock divided by 2^n
  localparam int OSC_MHZ = 100;
  localparam int CLK_MHZ = 20;
  localparam logic [3:0] DIV_EXP_MIN = 4'h1;
  localparam logic [3:0] DIV_EXP_MAX = 4'h8;
  localparam int DIV_CNT_W = 8;
  // Error flag low time in clock cycles
  localparam int FLAG_LOW_MIN = 32;
  localparam int LOW_CNT_W = 6;
  // Reconfiguration pulse driven by the reader
  localparam int RECONF_LOW_NS = 2000;
  localparam int RECONF_LOW_CYC = (RECONF_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 7;
  // Scan instructions
  typedef enum logic [1:0] {
    INSTR_NONE = 2'h0,
    INSTR_READ = 2'h1,
    INSTR_INJECT = 2'h2
  } edc_instr_t;
endpackage

// ==== verilog/edc_if.sv ====
// Link between the error checker and its reader (scan host, core logic, system controller).
// Assumes every signal is driven from flip-flops on the shared clock.
interface edc_if;
  import edc_pkg::*;
  logic error_flag;
  edc_instr_t scan_instr;
  logic scan_capture;
  logic scan_shift;
  logic scan_update;
  logic scan_tdi;
  logic scan_tdo;
  logic core_capture;
  logic core_shift;
  logic core_dout;
  logic reconfig_n;
  modport dev(
    output error_flag, scan_tdo, core_dout,
    input scan_instr, scan_capture, scan_shift, scan_update, scan_tdi, core_capture, core_shift, reconfig_n
  );
  modport host(
    input error_flag, scan_tdo, core_dout,
    output scan_instr, scan_capture, scan_shift, scan_update, scan_tdi, core_capture, core_shift, reconfig_n
  );
endinterface

// ==== verilog/edc_msg_port.sv ====
// Update copy and shift register pair for one readout path of the error message.
// Assumes msg stays stable for several cycles after msg_valid.
module edc_msg_port
  import edc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [MSG_W-1:0] msg,
  input wire logic msg_valid,
  input wire logic capture,
  input wire logic shift,
  output logic dout
);
  logic [MSG_W-1:0] copy, next_copy;
  logic [MSG_W-1:0] shifter, next_shifter;
  logic pend, next_pend;

  // Copy waits while the shifter samples it, so write and read never meet
  always_comb begin
    next_copy = copy;
    next_pend = pend;
    next_shifter = shifter;
    if ((msg_valid || pend) && !capture) begin
      next_copy = msg;
      next_pend = 1'b0;
    end else if (msg_valid) begin
      next_pend = 1'b1;
    end
    if (capture) begin
      next_shifter = copy;
    end else if (shift) begin
      next_shifter = {1'b0, shifter[MSG_W-1:1]}; // Least significant bit first
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      copy <= '0;
      pend <= 1'b0;
      shifter <= '0;
    end else if (ce) begin
      copy <= next_copy;
      pend <= next_pend;
      shifter <= next_shifter;
    end
  end

  assign dout = shifter[0];
endmodule

// ==== verilog/edc_dev_end.sv ====
// Configuration memory checker: frame CRC, error search, message readout, fault injection.
// Assumes the reader end drives the link on the same clock; reconfig_n low acts as device reset.
// Notes on behaviour
// - Syndrome register holds frame CRC; flag follows it
// - Keep 46-bit message: type, location, syndrome
// - Location only for single or adjacent double
// - Message readable by scan or core path
// - Scan copy follows message, gated against capture
// - Core copy follows message, gated against capture
// - Scan shifter captures copy, shifts on read
// - Core shifter captures copy, shifts for logic
// - Scan injection register written by inject only
// - Update loads injection into active register
// - Start checking in user mode when enabled
// - Raise flag after search and message update
// - Flag low at least 32 cycles after pulse
// - Next bad frame overwrites message, flags again
// - Reader may unload at each flag rise
// - Checking runs until device reset
// - Checker steps at clock over 2^n, n 1..8
// - One frame checked per pass at that rate
// - System pulses reconfig low to repair
module edc_dev_end
  import edc_pkg::*;
#(
  parameter int FRAMES = 8,
  parameter int FRAME_BITS = 128
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic crc_enable,
  input wire logic config_done,
  input wire logic init_done,
  input wire logic [3:0] div_exp,
  edc_if.dev link,
  output logic checking,
  output logic [1:0] last_error_type
);
  localparam int FW = $clog2(FRAMES);
  localparam int BW = $clog2(FRAME_BITS);

  typedef enum logic [2:0] {
    D_WAIT = 3'h0,
    D_CRC = 3'h1,
    D_SEARCH = 3'h2,
    D_REPORT = 3'h3,
    D_SETTLE = 3'h4,
    D_FLAG = 3'h5,
    D_LOW = 3'h6
  } edc_dstate_t;

  edc_dstate_t state, next_state;
  logic run_rst;
  logic [3:0] div_e;
  logic [DIV_CNT_W-1:0] div_cnt, next_div_cnt, div_mask;
  logic tick;
  logic [FW-1:0] frame_idx, next_frame_idx;
  logic [BW-1:0] bit_idx, next_bit_idx;
  logic [SYN_W-1:0] frame_syndrome, next_frame_syndrome;
  logic [SYN_W-1:0] probe, next_probe, probe_nx, crc_nx;
  logic [MSG_W-1:0] error_message, next_error_message;
  logic msg_valid, next_msg_valid;
  logic error_flag, next_error_flag;
  logic next_checking;
  logic [LOW_CNT_W-1:0] low_cnt, next_low_cnt;
  logic [FI_W-1:0] scan_fault_injection, next_scan_fault_injection;
  logic [FI_W-1:0] active_fault_injection, next_active_fault_injection;
  logic fi_apply, next_fi_apply;
  logic [FRAME_BITS-1:0] cfg_mem [FRAMES];
  logic [FRAME_BITS-1:0] fi_mask;
  logic [FW-1:0] fi_frame;
  logic [BW-1:0] fi_bit;
  logic [1:0] fi_type;

  // Multiply by x modulo the check polynomial
  function automatic logic [SYN_W-1:0] mulx(input logic [SYN_W-1:0] s);
    mulx = {s[SYN_W-2:0], 1'b0} ^ (s[SYN_W-1] ? CRC_POLY : '0);
  endfunction

  assign run_rst = srst || !link.reconfig_n;

  // Checker step strobe, one per 2^n clocks
  always_comb begin
    div_e = div_exp;
    if (div_exp < DIV_EXP_MIN) begin
      div_e = DIV_EXP_MIN;
    end else if (div_exp > DIV_EXP_MAX) begin
      div_e = DIV_EXP_MAX;
    end
    div_mask = DIV_CNT_W'((9'h1 << div_e) - 9'h1);
    tick = (div_cnt & div_mask) == div_mask;
    next_div_cnt = checking ? div_cnt + 1'b1 : '0;
  end

  // Serial check of one frame bit and next search probe
  assign crc_nx = mulx(frame_syndrome) ^ (cfg_mem[frame_idx][bit_idx] ? CRC_POLY : '0);
  assign probe_nx = mulx(probe);

  // Main sequence: check, search, report, flag, rest
  always_comb begin
    next_state = state;
    next_frame_idx = frame_idx;
    next_bit_idx = bit_idx;
    next_frame_syndrome = frame_syndrome;
    next_probe = probe;
    next_error_message = error_message;
    next_msg_valid = 1'b0;
    next_error_flag = error_flag;
    next_checking = checking;
    next_low_cnt = low_cnt;
    case (state)
      D_WAIT: begin
        if (crc_enable && config_done && init_done) begin
          next_checking = 1'b1;
          next_bit_idx = BW'(FRAME_BITS - 1);
          next_frame_syndrome = '0;
          next_state = D_CRC;
        end
      end
      D_CRC: begin
        if (tick) begin
          next_frame_syndrome = crc_nx;
          next_bit_idx = bit_idx - 1'b1;
          if (bit_idx == '0) begin
            if (crc_nx == '0) begin
              next_frame_syndrome = '0;
              next_bit_idx = BW'(FRAME_BITS - 1);
              next_frame_idx = (frame_idx == FW'(FRAMES - 1)) ? '0 : frame_idx + 1'b1;
            end else begin
              next_probe = CRC_POLY;
              next_bit_idx = '0;
              next_state = D_SEARCH;
            end
          end
        end
      end
      D_SEARCH: begin
        if (tick) begin
          next_error_message[SYN_W-1:0] = frame_syndrome;
          next_error_message[LOCF_HI:LOCF_LO] = LOCF_W'(frame_idx);
          next_error_message[LOCB_HI:LOCB_LO] = LOCB_W'(bit_idx);
          next_state = D_REPORT;
          if (frame_syndrome == probe) begin
            next_error_message[TYPE_HI:TYPE_LO] = ERR_SINGLE;
          end else if (bit_idx != BW'(FRAME_BITS - 1) && frame_syndrome == (probe ^ probe_nx)) begin
            next_error_message[TYPE_HI:TYPE_LO] = ERR_DOUBLE;
          end else if (bit_idx == BW'(FRAME_BITS - 1)) begin
            next_error_message[TYPE_HI:TYPE_LO] = ERR_MULTI;
            next_error_message[LOCF_HI:LOCB_LO] = '0;
          end else begin
            next_error_message = error_message;
            next_probe = probe_nx;
            next_bit_idx = bit_idx + 1'b1;
            next_state = D_SEARCH;
          end
        end
      end
      D_REPORT: begin
        next_msg_valid = 1'b1;
        next_state = D_SETTLE;
      end
      D_SETTLE: begin
        next_error_flag = 1'b1;
        next_state = D_FLAG;
      end
      D_FLAG: begin
        if (tick) begin
          next_error_flag = 1'b0;
          next_low_cnt = '0;
          next_state = D_LOW;
        end
      end
      D_LOW: begin
        next_low_cnt = low_cnt + 1'b1;
        if (low_cnt == LOW_CNT_W'(FLAG_LOW_MIN - 1)) begin
          next_frame_syndrome = '0;
          next_bit_idx = BW'(FRAME_BITS - 1);
          next_frame_idx = (frame_idx == FW'(FRAMES - 1)) ? '0 : frame_idx + 1'b1;
          next_state = D_CRC;
        end
      end
      default: begin
        next_state = D_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (run_rst) begin
      state <= D_WAIT;
      div_cnt <= '0;
      frame_idx <= '0;
      bit_idx <= '0;
      frame_syndrome <= '0;
      probe <= '0;
      error_message <= '0;
      msg_valid <= 1'b0;
      error_flag <= 1'b0;
      checking <= 1'b0;
      low_cnt <= '0;
    end else if (ce) begin
      state <= next_state;
      div_cnt <= next_div_cnt;
      frame_idx <= next_frame_idx;
      bit_idx <= next_bit_idx;
      frame_syndrome <= next_frame_syndrome;
      probe <= next_probe;
      error_message <= next_error_message;
      msg_valid <= next_msg_valid;
      error_flag <= next_error_flag;
      checking <= next_checking;
      low_cnt <= next_low_cnt;
    end
  end

  // Scan fault injection: shift under inject, load active on update
  always_comb begin
    next_scan_fault_injection = scan_fault_injection;
    next_active_fault_injection = active_fault_injection;
    next_fi_apply = 1'b0;
    if (link.scan_instr == INSTR_INJECT && link.scan_shift) begin
      next_scan_fault_injection = {link.scan_tdi, scan_fault_injection[FI_W-1:1]};
    end
    if (link.scan_instr == INSTR_INJECT && link.scan_update) begin
      next_active_fault_injection = scan_fault_injection;
      next_fi_apply = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (run_rst) begin
      scan_fault_injection <= '0;
      active_fault_injection <= '0;
      fi_apply <= 1'b0;
    end else if (ce) begin
      scan_fault_injection <= next_scan_fault_injection;
      active_fault_injection <= next_active_fault_injection;
      fi_apply <= next_fi_apply;
    end
  end

  // Bits to flip for the active injection, none if out of range
  assign fi_type = active_fault_injection[FI_TYPE_HI:FI_TYPE_LO];
  assign fi_frame = FW'(active_fault_injection[FI_FR_HI:FI_FR_LO]);
  assign fi_bit = BW'(active_fault_injection[FI_BIT_HI:FI_BIT_LO]);
  always_comb begin
    fi_mask = '0;
    if (fi_type != ERR_NONE && int'(active_fault_injection[FI_FR_HI:FI_FR_LO]) < FRAMES &&
        int'(active_fault_injection[FI_BIT_HI:FI_BIT_LO]) < FRAME_BITS) begin
      fi_mask[fi_bit] = 1'b1;
      if (fi_type == ERR_DOUBLE && int'(active_fault_injection[FI_BIT_HI:FI_BIT_LO]) < FRAME_BITS - 1) begin
        fi_mask[fi_bit + BW'(1)] = 1'b1;
      end
    end
  end

  // Configuration frames: cleared by reconfiguration, corrupted by injection
  always_ff @(posedge clk) begin
    if (run_rst) begin
      for (int f = 0; f < FRAMES; f++) begin
        cfg_mem[f] <= '0;
      end
    end else if (ce && fi_apply) begin
      cfg_mem[fi_frame] <= cfg_mem[fi_frame] ^ fi_mask;
    end
  end

  // Two readout paths with the same message layout
  edc_msg_port u_scan_port (
    .clk(clk),
    .srst(run_rst),
    .ce(ce),
    .msg(error_message),
    .msg_valid(msg_valid),
    .capture(link.scan_capture && link.scan_instr == INSTR_READ),
    .shift(link.scan_shift && link.scan_instr == INSTR_READ),
    .dout(link.scan_tdo)
  );

  edc_msg_port u_core_port (
    .clk(clk),
    .srst(run_rst),
    .ce(ce),
    .msg(error_message),
    .msg_valid(msg_valid),
    .capture(link.core_capture),
    .shift(link.core_shift),
    .dout(link.core_dout)
  );

  assign link.error_flag = error_flag;
  assign last_error_type = error_message[TYPE_HI:TYPE_LO];
endmodule

// ==== verilog/edc_host_end.sv ====
// Reader end: unloads error messages, injects faults, pulses reconfiguration.
// Assumes the checker end shares this clock and answers capture and shift in the next cycle.
module edc_host_end
  import edc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic scan_read_req,
  input wire logic inject_req,
  input wire logic [FI_W-1:0] inject_value,
  input wire logic auto_reconfig,
  edc_if.host link,
  output logic busy,
  output logic msg_valid,
  output logic msg_via_scan,
  output logic [MSG_W-1:0] msg_data
);
  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_CAP = 3'h1,
    H_SHIFT = 3'h2,
    H_INJ = 3'h3,
    H_UPD = 3'h4,
    H_RECONF = 3'h5
  } edc_hstate_t;

  edc_hstate_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [MSG_W-1:0] next_msg_data;
  logic [FI_W-1:0] ibuf, next_ibuf;
  logic flag_d, flag_pend, next_flag_pend;
  logic next_msg_valid, next_msg_via_scan;
  logic next_busy;
  edc_instr_t instr, next_instr;
  logic scap, next_scap, sshift, next_sshift, supd, next_supd, tdi, next_tdi;
  logic ccap, next_ccap, cshift, next_cshift, rcfg_n, next_rcfg_n;

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_msg_data = msg_data;
    next_ibuf = ibuf;
    next_flag_pend = flag_pend || (link.error_flag && !flag_d);
    next_msg_valid = 1'b0;
    next_msg_via_scan = msg_via_scan;
    next_instr = instr;
    next_scap = 1'b0;
    next_sshift = sshift;
    next_supd = 1'b0;
    next_tdi = tdi;
    next_ccap = 1'b0;
    next_cshift = cshift;
    next_rcfg_n = rcfg_n;
    case (state)
      H_IDLE: begin
        if (next_flag_pend) begin
          next_flag_pend = 1'b0;
          next_msg_via_scan = 1'b0;
          next_ccap = 1'b1;
          next_state = H_CAP;
        end else if (scan_read_req) begin
          next_msg_via_scan = 1'b1;
          next_instr = INSTR_READ;
          next_scap = 1'b1;
          next_state = H_CAP;
        end else if (inject_req) begin
          next_instr = INSTR_INJECT;
          next_sshift = 1'b1;
          next_tdi = inject_value[0];
          next_ibuf = inject_value >> 1;
          next_cnt = '0;
          next_state = H_INJ;
        end
      end
      H_CAP: begin
        next_cnt = '0;
        next_sshift = msg_via_scan;
        next_cshift = !msg_via_scan;
        next_state = H_SHIFT;
      end
      H_SHIFT: begin
        next_msg_data = {msg_via_scan ? link.scan_tdo : link.core_dout, msg_data[MSG_W-1:1]};
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(MSG_W - 1)) begin
          next_sshift = 1'b0;
          next_cshift = 1'b0;
          next_instr = INSTR_NONE;
          next_msg_valid = 1'b1;
          next_cnt = '0;
          if (!msg_via_scan && auto_reconfig) begin
            next_rcfg_n = 1'b0;
            next_state = H_RECONF;
          end else begin
            next_state = H_IDLE;
          end
        end
      end
      H_INJ: begin
        if (cnt == CNT_W'(FI_W - 1)) begin
          next_sshift = 1'b0;
          next_supd = 1'b1;
          next_state = H_UPD;
        end else begin
          next_tdi = ibuf[0];
          next_ibuf = ibuf >> 1;
          next_cnt = cnt + 1'b1;
        end
      end
      H_UPD: begin
        next_instr = INSTR_NONE;
        next_tdi = 1'b0;
        next_state = H_IDLE;
      end
      H_RECONF: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(RECONF_LOW_CYC - 1)) begin
          next_rcfg_n = 1'b1;
          next_flag_pend = 1'b0;
          next_state = H_IDLE;
        end
      end
      default: begin
        next_state = H_IDLE;
      end
    endcase
    next_busy = next_state != H_IDLE;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= H_IDLE;
      cnt <= '0;
      msg_data <= '0;
      ibuf <= '0;
      flag_d <= 1'b0;
      flag_pend <= 1'b0;
      msg_valid <= 1'b0;
      msg_via_scan <= 1'b0;
      busy <= 1'b0;
      instr <= INSTR_NONE;
      scap <= 1'b0;
      sshift <= 1'b0;
      supd <= 1'b0;
      tdi <= 1'b0;
      ccap <= 1'b0;
      cshift <= 1'b0;
      rcfg_n <= 1'b1;
    end else if (ce) begin
      state <= next_state;
      cnt <= next_cnt;
      msg_data <= next_msg_data;
      ibuf <= next_ibuf;
      flag_d <= link.error_flag;
      flag_pend <= next_flag_pend;
      msg_valid <= next_msg_valid;
      msg_via_scan <= next_msg_via_scan;
      busy <= next_busy;
      instr <= next_instr;
      scap <= next_scap;
      sshift <= next_sshift;
      supd <= next_supd;
      tdi <= next_tdi;
      ccap <= next_ccap;
      cshift <= next_cshift;
      rcfg_n <= next_rcfg_n;
    end
  end

  // Link outputs straight from flip-flops
  assign link.scan_instr = instr;
  assign link.scan_capture = scap;
  assign link.scan_shift = sshift;
  assign link.scan_update = supd;
  assign link.scan_tdi = tdi;
  assign link.core_capture = ccap;
  assign link.core_shift = cshift;
  assign link.reconfig_n = rcfg_n;
endmodule

// ==== bench/edc_link_checker.sv ====
// Assertion checker for the link between the error checker and its reader.
// Assumes one clock, sync reset srst, and the checker stepping every 2 clocks (div_exp 1).
module edc_link_checker
  import edc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic error_flag,
  input wire edc_instr_t scan_instr,
  input wire logic scan_capture,
  input wire logic scan_shift,
  input wire logic scan_update,
  input wire logic scan_tdo,
  input wire logic core_capture,
  input wire logic core_shift,
  input wire logic core_dout,
  input wire logic reconfig_n
);
  logic [5:0] gap_cnt, next_gap_cnt, sh_cnt, next_sh_cnt, rc_cnt, next_rc_cnt;
  logic [4:0] inj_cnt, next_inj_cnt;
  // Flag low time, core shift run, injection shifts and reconfig pulse length
  always_comb begin
    next_gap_cnt = error_flag ? 6'h00 : gap_cnt + {5'h00, gap_cnt != 6'h3f};
    next_sh_cnt = core_capture ? 6'h00 : sh_cnt + {5'h00, core_shift};
    next_inj_cnt = (scan_instr != INSTR_INJECT) ? 5'h00 : inj_cnt + {4'h0, scan_shift};
    next_rc_cnt = reconfig_n ? 6'h00 : rc_cnt + 6'h01;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      gap_cnt <= 6'h3f;
      sh_cnt <= 6'h00;
      inj_cnt <= 5'h00;
      rc_cnt <= 6'h00;
    end else begin
      gap_cnt <= next_gap_cnt;
      sh_cnt <= next_sh_cnt;
      inj_cnt <= next_inj_cnt;
      rc_cnt <= next_rc_cnt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  AST_FLAG_GAP: assert property ($rose(error_flag) |-> gap_cnt >= 6'h20)
    else $error("flag rose too soon after last pulse");
  AST_FLAG_SHORT: assert property ($rose(error_flag) |-> ##[1:2] !error_flag)
    else $error("flag pulse too long");
  AST_FLAG_RECONF: assert property (!reconfig_n |=> !error_flag)
    else $error("flag high during device reset");
  AST_CORE_FOLLOWS: assert property ($rose(error_flag) |-> ##[1:80] core_capture)
    else $error("no core read after flag rise");
  AST_CORE_46: assert property ($fell(core_shift) |-> sh_cnt == 6'h2e)
    else $error("core read shift count wrong");
  AST_INJ_21: assert property (scan_update && scan_instr == INSTR_INJECT |-> inj_cnt == 5'h15)
    else $error("injection update without 21 shifts");
  AST_SCAN_HOLD: assert property (reconfig_n && !((scan_shift || scan_capture) && scan_instr == INSTR_READ)
    |=> $stable(scan_tdo))
    else $error("scan output moved without read instruction");
  AST_CORE_HOLD: assert property (reconfig_n && !core_shift && !core_capture |=> $stable(core_dout))
    else $error("core output moved without shift or capture");
  AST_RECONF_LEN: assert property ($rose(reconfig_n) |-> rc_cnt == 6'h28)
    else $error("reconfig pulse length wrong");
  cover property ($rose(error_flag));
  cover property (scan_capture && scan_instr == INSTR_READ);
  cover property ($rose(reconfig_n));
endmodule

// ==== bench/testbench.sv ====
// Self-checking bench: checker end and reader end joined by the link interface.
// Assumes a 20 MHz clock, two frames of 16 bits and the checker stepping every 2 clocks.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import edc_pkg::*;
  logic clk, srst, ce, crc_enable, config_done, init_done, scan_read_req, inject_req, auto_reconfig;
  logic checking, busy, msg_valid, msg_via_scan;
  logic [3:0] div_exp;
  logic [1:0] last_error_type;
  logic [FI_W-1:0] inject_value;
  logic [MSG_W-1:0] msg_data, m_a, m_b, e_multi, e_f1;
  int bad_count, num_checks;
  edc_if edc_if_inst();
  edc_dev_end #(.FRAMES(2), .FRAME_BITS(16)) edc_dev_end_inst (.clk(clk), .srst(srst), .ce(ce),
    .crc_enable(crc_enable), .config_done(config_done), .init_done(init_done), .div_exp(div_exp),
    .link(edc_if_inst.dev), .checking(checking), .last_error_type(last_error_type));
  edc_host_end edc_host_end_inst (.clk(clk), .srst(srst), .ce(ce), .scan_read_req(scan_read_req),
    .inject_req(inject_req), .inject_value(inject_value), .auto_reconfig(auto_reconfig),
    .link(edc_if_inst.host), .busy(busy), .msg_valid(msg_valid), .msg_via_scan(msg_via_scan), .msg_data(msg_data));
  edc_link_checker edc_link_checker_inst (.clk(clk), .srst(srst), .error_flag(edc_if_inst.error_flag),
    .scan_instr(edc_if_inst.scan_instr), .scan_capture(edc_if_inst.scan_capture),
    .scan_shift(edc_if_inst.scan_shift), .scan_update(edc_if_inst.scan_update), .scan_tdo(edc_if_inst.scan_tdo),
    .core_capture(edc_if_inst.core_capture), .core_shift(edc_if_inst.core_shift),
    .core_dout(edc_if_inst.core_dout), .reconfig_n(edc_if_inst.reconfig_n));
  // Clock source
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic report_and_stop();
    if (bad_count == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [MSG_W-1:0] got, input logic [MSG_W-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Remainder of x^k by the frame polynomial
  function automatic logic [SYN_W-1:0] xpow(input int k);
    logic [SYN_W-1:0] r;
    r = 32'h00000001;
    repeat (k) r = r[SYN_W-1] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    return r;
  endfunction
  // Hold a request until the reader shows the matching instruction
  task automatic request(input logic is_read, input logic [FI_W-1:0] v);
    int n;
    n = 0;
    // Let the instruction of an earlier transfer clear first, or it would be taken for this one
    while (edc_if_inst.scan_instr !== INSTR_NONE && n < 300) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    inject_value <= v;
    scan_read_req <= is_read;
    inject_req <= ~is_read;
    while (edc_if_inst.scan_instr !== (is_read ? INSTR_READ : INSTR_INJECT) && n < 300) begin
      @(negedge clk);
      n++;
    end
    chk_bit(busy, 1'b1);
    @(posedge clk);
    scan_read_req <= 1'b0;
    inject_req <= 1'b0;
    chk_bit(n < 300, 1'b1);
  endtask
  task automatic wait_msg(input logic want_scan, output logic [MSG_W-1:0] m);
    int n;
    n = 0;
    @(negedge clk);
    while (!(msg_valid === 1'b1 && msg_via_scan === want_scan) && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk_bit(n < 4000, 1'b1);
    m = msg_data;
  endtask
  task automatic wait_repair();
    int n;
    n = 0;
    while (edc_if_inst.reconfig_n !== 1'b0 && n < 400) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    chk_bit(checking, 1'b0);
    while (edc_if_inst.reconfig_n !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    repeat (4) @(negedge clk);
    chk_bit(checking, 1'b1);
  endtask
  task automatic t_start();
    repeat (2) @(negedge clk);
    chk_bit(checking, 1'b0);
    chk_bit(edc_if_inst.error_flag, 1'b0);
    @(posedge clk);
    crc_enable <= 1'b1;
    config_done <= 1'b1;
    repeat (10) @(negedge clk);
    chk_bit(checking, 1'b0);
    @(posedge clk);
    init_done <= 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(checking, 1'b1);
  endtask
  task automatic t_single();
    request(1'b0, {2'h1, 9'h000, 10'h005});
    wait_msg(1'b0, m_a);
    chk(m_a, {ERR_SINGLE, 4'h0, 8'h05, xpow(37)});
    chk_bit(last_error_type == ERR_SINGLE, 1'b1);
    wait_repair();
  endtask
  task automatic t_double();
    request(1'b0, {2'h2, 9'h001, 10'h007});
    wait_msg(1'b0, m_a);
    chk(m_a, {ERR_DOUBLE, 4'h1, 8'h07, xpow(39) ^ xpow(40)});
    wait_repair();
  endtask
  task automatic t_multi_scan();
    @(posedge clk);
    auto_reconfig <= 1'b0;
    request(1'b0, {2'h1, 9'h000, 10'h002});
    request(1'b0, {2'h1, 9'h000, 10'h009});
    repeat (2) wait_msg(1'b0, m_a);
    chk(m_a, e_multi);
    request(1'b1, {FI_W{1'b0}});
    wait_msg(1'b1, m_b);
    chk(m_b, e_multi);
  endtask
  task automatic t_overwrite();
    request(1'b0, {2'h1, 9'h001, 10'h004});
    repeat (2) wait_msg(1'b0, m_a);
    wait_msg(1'b0, m_a);
    wait_msg(1'b0, m_b);
    chk(m_a, e_multi);
    chk(m_b, e_f1);
  endtask
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    ce = 1'b1;
    crc_enable = 1'b0;
    config_done = 1'b0;
    init_done = 1'b0;
    div_exp = 4'h1;
    scan_read_req = 1'b0;
    inject_req = 1'b0;
    inject_value = {FI_W{1'b0}};
    auto_reconfig = 1'b1;
    bad_count = 0;
    num_checks = 0;
    e_multi = {ERR_MULTI, 4'h0, 8'h00, xpow(34) ^ xpow(41)};
    e_f1 = {ERR_SINGLE, 4'h1, 8'h04, xpow(36)};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    t_start();
    t_single();
    t_double();
    t_multi_scan();
    t_overwrite();
    report_and_stop();
  end
endmodule
